/* hw/iss_consts.vh */
`ifndef ISS_CONSTS_VH
`define ISS_CONSTS_VH

// operation codes on op_i
`define ISS_OP_QSUB 3'h0
`define ISS_OP_XSUB 3'h1
`define ISS_OP_HSWAP 3'h2
`define ISS_OP_TRAP 3'h3
`define ISS_OP_NTRAP 3'h4
`define ISS_OP_UNLINK 3'h5
`define ISS_OP_DBGWR 3'h6

// never-taken trap operand size on size_i
`define ISS_SZ_NONE 2'h0
`define ISS_SZ_W16 2'h1
`define ISS_SZ_L32 2'h2

// program counter advance per operand size
`define ISS_PC_INC_NONE 32'h00000002
`define ISS_PC_INC_W16 32'h00000004
`define ISS_PC_INC_L32 32'h00000006

// stack adjustments
`define ISS_SP_LONG 32'h00000004
`define ISS_SP_WORD 32'h00000002

// memory access size on mem_size_o
`define ISS_MSZ_WORD 1'b0
`define ISS_MSZ_LONG 1'b1

`endif

/* hw/iss_alu.v */
`timescale 1ns/1ps
// =====================================================================
// combinational arithmetic for the register-result operations
module iss_alu (
    // operands
    input wire [2:0] op_i,
    input wire [31:0] dst_i,
    input wire [31:0] src_i,
    input wire xflag_i,
    // result
    output reg [31:0] res_o
);
`include "iss_consts.vh"

    always @* begin
        case (op_i)
            `ISS_OP_QSUB: res_o = dst_i - src_i;
            `ISS_OP_XSUB: res_o = dst_i - src_i - {31'h00000000, xflag_i};
            `ISS_OP_HSWAP: res_o = {dst_i[15:0], dst_i[31:16]};
            default: res_o = dst_i;
        endcase
    end

endmodule // iss_alu

/* hw/iss_exec.v */
`timescale 1ns/1ps
module iss_exec (
    // clock and reset
    input wire sys_clk_i,
    input wire sys_rst_i,
    // operation request
    input wire start_i,
    input wire [2:0] op_i,
    input wire [1:0] size_i,
    input wire [31:0] dst_i,
    input wire [31:0] src_i,
    input wire xflag_i,
    input wire [31:0] pc_i,
    input wire [31:0] sp_i,
    input wire [15:0] status_register_i,
    input wire [15:0] format_i,
    input wire [31:0] vector_i,
    input wire [31:0] src_addr_i,
    // memory port
    output reg mem_req_o,
    output reg mem_we_o,
    output reg mem_size_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    // register writeback
    output reg rf_we_o,
    output reg [31:0] rf_data_o,
    output reg sp_we_o,
    output reg [31:0] sp_o,
    output reg pc_we_o,
    output reg [31:0] pc_o,
    // debug module
    output reg dbg_we_o,
    output reg [63:0] dbg_data_o,
    // status
    output reg busy_o,
    output reg done_o
);
`include "iss_consts.vh"

    // =================================================================
    // states
    localparam ST_IDLE = 3'h0;
    localparam ST_PUSH_PC = 3'h1;
    localparam ST_PUSH_STAT = 3'h2;
    localparam ST_PUSH_FMT = 3'h3;
    localparam ST_POP = 3'h4;
    localparam ST_DBG_HI = 3'h5;
    localparam ST_DBG_LO = 3'h6;

    function [31:0] ntrap_inc;
        input [1:0] sz;
        begin
            case (sz)
                `ISS_SZ_W16: ntrap_inc = `ISS_PC_INC_W16;
                `ISS_SZ_L32: ntrap_inc = `ISS_PC_INC_L32;
                default: ntrap_inc = `ISS_PC_INC_NONE;
            endcase
        end
    endfunction

    reg [2:0] state_r;
    reg [31:0] sp_r;
    reg [31:0] pc_r;
    reg [15:0] stat_r;
    reg [15:0] fmt_r;
    reg [31:0] vec_r;
    reg [31:0] addr_r;
    wire [31:0] alu_res;

    iss_alu u_alu (
        .op_i(op_i),
        .dst_i(dst_i),
        .src_i(src_i),
        .xflag_i(xflag_i),
        .res_o(alu_res)
    );

    // =================================================================
    // sequencer
    // a memory step holds req until ack; outputs reset to idle values
    always @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_r <= ST_IDLE;
            sp_r <= 32'h00000000;
            pc_r <= 32'h00000000;
            stat_r <= 16'h0000;
            fmt_r <= 16'h0000;
            vec_r <= 32'h00000000;
            addr_r <= 32'h00000000;
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_size_o <= `ISS_MSZ_LONG;
            mem_addr_o <= 32'h00000000;
            mem_wdata_o <= 32'h00000000;
            rf_we_o <= 1'b0;
            rf_data_o <= 32'h00000000;
            sp_we_o <= 1'b0;
            sp_o <= 32'h00000000;
            pc_we_o <= 1'b0;
            pc_o <= 32'h00000000;
            dbg_we_o <= 1'b0;
            dbg_data_o <= 64'h0000000000000000;
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            rf_we_o <= 1'b0;
            sp_we_o <= 1'b0;
            pc_we_o <= 1'b0;
            dbg_we_o <= 1'b0;
            done_o <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start_i) begin
                        case (op_i)
                            `ISS_OP_QSUB, `ISS_OP_XSUB, `ISS_OP_HSWAP: begin
                                rf_we_o <= 1'b1;
                                rf_data_o <= alu_res;
                                done_o <= 1'b1;
                            end
                            `ISS_OP_NTRAP: begin
                                pc_we_o <= 1'b1;
                                pc_o <= pc_i + ntrap_inc(size_i);
                                done_o <= 1'b1;
                            end
                            `ISS_OP_TRAP: begin
                                sp_r <= sp_i - `ISS_SP_LONG;
                                stat_r <= status_register_i;
                                fmt_r <= format_i;
                                vec_r <= vector_i;
                                mem_req_o <= 1'b1;
                                mem_we_o <= 1'b1;
                                mem_size_o <= `ISS_MSZ_LONG;
                                mem_addr_o <= sp_i - `ISS_SP_LONG;
                                mem_wdata_o <= pc_i;
                                busy_o <= 1'b1;
                                state_r <= ST_PUSH_PC;
                            end
                            `ISS_OP_UNLINK: begin
                                // frame register becomes the stack pointer, then is popped
                                sp_r <= dst_i;
                                mem_req_o <= 1'b1;
                                mem_we_o <= 1'b0;
                                mem_size_o <= `ISS_MSZ_LONG;
                                mem_addr_o <= dst_i;
                                busy_o <= 1'b1;
                                state_r <= ST_POP;
                            end
                            `ISS_OP_DBGWR: begin
                                addr_r <= src_addr_i;
                                mem_req_o <= 1'b1;
                                mem_we_o <= 1'b0;
                                mem_size_o <= `ISS_MSZ_LONG;
                                mem_addr_o <= src_addr_i;
                                busy_o <= 1'b1;
                                state_r <= ST_DBG_HI;
                            end
                            default: begin
                                done_o <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_PUSH_PC: begin
                    if (mem_ack_i) begin
                        sp_r <= sp_r - `ISS_SP_WORD;
                        mem_size_o <= `ISS_MSZ_WORD;
                        mem_addr_o <= sp_r - `ISS_SP_WORD;
                        mem_wdata_o <= {16'h0000, stat_r};
                        state_r <= ST_PUSH_STAT;
                    end
                end
                ST_PUSH_STAT: begin
                    if (mem_ack_i) begin
                        sp_r <= sp_r - `ISS_SP_WORD;
                        mem_addr_o <= sp_r - `ISS_SP_WORD;
                        mem_wdata_o <= {16'h0000, fmt_r};
                        state_r <= ST_PUSH_FMT;
                    end
                end
                ST_PUSH_FMT: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        sp_we_o <= 1'b1;
                        sp_o <= sp_r;
                        pc_we_o <= 1'b1;
                        pc_o <= vec_r;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_POP: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        rf_we_o <= 1'b1;
                        rf_data_o <= mem_rdata_i;
                        sp_we_o <= 1'b1;
                        sp_o <= sp_r + `ISS_SP_LONG;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_DBG_HI: begin
                    if (mem_ack_i) begin
                        dbg_data_o[63:32] <= mem_rdata_i;
                        mem_addr_o <= addr_r + `ISS_SP_LONG;
                        state_r <= ST_DBG_LO;
                    end
                end
                ST_DBG_LO: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        dbg_data_o[31:0] <= mem_rdata_i;
                        dbg_we_o <= 1'b1;
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    mem_req_o <= 1'b0;
                    busy_o <= 1'b0;
                end
            endcase
        end
    end

endmodule // iss_exec

/* tb/iss_exec_assertions.sv */
`timescale 1ns/1ps
`include "iss_consts.vh"
module iss_exec_chk (
    // clock, reset and request
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire start_i,
    input wire [2:0] op_i,
    input wire [1:0] size_i,
    input wire [31:0] dst_i,
    input wire [31:0] src_i,
    input wire xflag_i,
    input wire [31:0] pc_i,
    input wire [31:0] sp_i,
    input wire [31:0] vector_i,
    input wire [31:0] src_addr_i,
    // memory port
    input wire mem_req_o,
    input wire mem_we_o,
    input wire mem_size_o,
    input wire [31:0] mem_addr_o,
    input wire [31:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [31:0] mem_rdata_i,
    // results
    input wire rf_we_o,
    input wire [31:0] rf_data_o,
    input wire sp_we_o,
    input wire [31:0] sp_o,
    input wire pc_we_o,
    input wire [31:0] pc_o,
    input wire dbg_we_o,
    input wire [63:0] dbg_data_o,
    input wire busy_o,
    input wire done_o
);
    // =========================================
    // helpers
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    wire go = start_i && !busy_o;
    wire [31:0] ntinc = (size_i == `ISS_SZ_W16) ? `ISS_PC_INC_W16 :
        (size_i == `ISS_SZ_L32) ? `ISS_PC_INC_L32 : `ISS_PC_INC_NONE;
    sequence s_trap_go;
        go && op_i == `ISS_OP_TRAP;
    endsequence
    sequence s_pc_push;
        mem_req_o && mem_we_o && mem_size_o && mem_addr_o == $past(sp_i) - `ISS_SP_LONG
            && mem_wdata_o == $past(pc_i);
    endsequence
    // last push is the only word write at sp-8
    sequence s_fmt_ack;
        mem_req_o && mem_ack_i && mem_we_o && !mem_size_o && mem_addr_o == sp_i - 32'h8;
    endsequence
    // =========================================
    // properties
    AST_QSUB:
    assert property (go && op_i == `ISS_OP_QSUB |=> rf_we_o && done_o
        && rf_data_o == $past(dst_i) - $past(src_i)) else $error("quick subtract wrong");
    AST_XSUB:
    assert property (go && op_i == `ISS_OP_XSUB |=> rf_we_o
        && rf_data_o == $past(dst_i) - $past(src_i) - $past(xflag_i))
        else $error("extended subtract wrong");
    AST_SWAP:
    assert property (go && op_i == `ISS_OP_HSWAP |=> rf_we_o
        && {rf_data_o[15:0], rf_data_o[31:16]} == $past(dst_i)) else $error("swap wrong");
    AST_NTRAP:
    assert property (go && op_i == `ISS_OP_NTRAP |=> pc_we_o && done_o
        && pc_o == $past(pc_i) + $past(ntinc)) else $error("pc advance wrong");
    AST_TRAP_PUSH:
    assert property (s_trap_go |=> s_pc_push) else $error("first trap push wrong");
    AST_TRAP_END:
    assert property (s_fmt_ack |=> sp_we_o && pc_we_o && done_o && !busy_o
        && sp_o == $past(sp_i) - 32'h8 && pc_o == $past(vector_i)) else $error("trap end wrong");
    AST_UNLINK_END:
    assert property (op_i == `ISS_OP_UNLINK && mem_req_o && mem_ack_i |=> rf_we_o && sp_we_o
        && rf_data_o == $past(mem_rdata_i) && sp_o == $past(dst_i) + `ISS_SP_LONG)
        else $error("unlink end wrong");
    AST_DBG:
    assert property (op_i == `ISS_OP_DBGWR && mem_req_o && mem_ack_i
        && mem_addr_o == src_addr_i + 32'h4 |=> dbg_we_o && done_o
        && dbg_data_o[31:0] == $past(mem_rdata_i)) else $error("debug write wrong");
endmodule // iss_exec_chk
bind iss_exec iss_exec_chk u_iss_exec_chk (.*);

/* tb/tb_instruction_subset_semantics.sv */
`timescale 1ns/1ps
`include "iss_consts.vh"
module tb_instruction_subset_semantics;
    typedef struct packed {logic [2:0] op; logic [1:0] sz; logic [31:0] d; logic [31:0] s;
        logic x; logic [31:0] e;} iss_row_t;
    localparam logic [31:0] RDK = 32'h5A5A0F0F;
    logic sys_clk_i, sys_rst_i, start_i, xflag_i, mem_ack_i;
    logic [2:0] op_i;
    logic [1:0] size_i;
    logic [15:0] status_register_i, format_i;
    logic [31:0] dst_i, src_i, pc_i, sp_i, vector_i, src_addr_i, mem_rdata_i;
    logic mem_req_o, mem_we_o, mem_size_o, rf_we_o, sp_we_o, pc_we_o, dbg_we_o, busy_o, done_o;
    logic [31:0] mem_addr_o, mem_wdata_o, rf_data_o, sp_o, pc_o;
    logic [63:0] dbg_data_o;
    logic [63:0] wlog[$];
    int err_count = 0;
    int n_tests = 0;
    iss_row_t rows[8] = '{
        '{`ISS_OP_QSUB, 2'h0, 32'h00000005, 32'h00000008, 1'b0, 32'hFFFFFFFD},
        '{`ISS_OP_QSUB, 2'h0, 32'h80000000, 32'h00000001, 1'b1, 32'h7FFFFFFF},
        '{`ISS_OP_XSUB, 2'h0, 32'h0000000A, 32'h00000003, 1'b1, 32'h00000006},
        '{`ISS_OP_XSUB, 2'h0, 32'h0, 32'h0, 1'b1, 32'hFFFFFFFF},
        '{`ISS_OP_HSWAP, 2'h0, 32'h12345678, 32'h0, 1'b0, 32'h56781234},
        '{`ISS_OP_NTRAP, `ISS_SZ_NONE, 32'h0, 32'h0, 1'b0, 32'h00000102},
        '{`ISS_OP_NTRAP, `ISS_SZ_W16, 32'h0, 32'h0, 1'b0, 32'h00000104},
        '{`ISS_OP_NTRAP, `ISS_SZ_L32, 32'h0, 32'h0, 1'b0, 32'h00000106}};

    iss_exec u_iss_exec (.*);

    initial sys_clk_i = 0;
    always #12.5 sys_clk_i = ~sys_clk_i;

    // =========================================
    // memory: acks every other cycle, so the first access of a request is acked at once and each later one sees a wait
    always @(posedge sys_clk_i) begin
        if (mem_req_o && mem_ack_i && mem_we_o) wlog.push_back({mem_addr_o, mem_wdata_o});
        #1;
        mem_ack_i = mem_req_o && !mem_ack_i;
        mem_rdata_i = mem_addr_o ^ RDK;
    end

    // =========================================
    // checking and ending
    task chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
        n_tests++;
        if (got !== ex) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task run(input logic [2:0] o);
        int k;
        op_i = o;
        start_i = 1;
        @(posedge sys_clk_i);
        #1;
        start_i = 0;
        for (k = 0; k < 40 && done_o !== 1'b1; k++) begin
            @(posedge sys_clk_i);
            #1;
        end
        chk("done", 1, done_o);
    endtask
    initial begin
        #100000;
        err_count++;
        test_done;
    end

    // =========================================
    // main sequence
    initial begin
        {sys_rst_i, start_i, xflag_i, mem_ack_i, op_i, size_i} = 9'h100;
        {status_register_i, format_i, dst_i, src_i, pc_i} = 0;
        {sp_i, vector_i, src_addr_i, mem_rdata_i} = 0;
        repeat (5) @(posedge sys_clk_i);
        #1;
        chk("reset", 3'b001, {busy_o, mem_req_o, mem_size_o});
        sys_rst_i = 0;
        pc_i = 32'h00000100;
        // back-to-back starts, one per cycle
        foreach (rows[i]) begin
            {op_i, size_i, dst_i, src_i, xflag_i} = {rows[i].op, rows[i].sz, rows[i].d,
                rows[i].s, rows[i].x};
            start_i = 1;
            @(posedge sys_clk_i);
            #1;
            if (op_i == `ISS_OP_NTRAP) chk("pc", {1'b1, rows[i].e}, {pc_we_o, pc_o});
            else chk("rf", {2'b11, rows[i].e}, {rf_we_o, done_o, rf_data_o});
        end
        start_i = 0;
        // let one edge pass so the next start is a fresh strobe
        @(posedge sys_clk_i);
        #1;
        {sp_i, pc_i, vector_i} = {32'h00001000, 32'h20000010, 32'h00000400};
        {status_register_i, format_i} = {16'h2704, 16'h4080};
        run(`ISS_OP_TRAP);
        chk("sp", {1'b1, 32'h00000FF8}, {sp_we_o, sp_o});
        chk("vec", {1'b1, 32'h00000400}, {pc_we_o, pc_o});
        chk("pushes", 3, wlog.size());
        chk("w0", {32'h00000FFC, 32'h20000010}, wlog[0]);
        chk("w1", {32'h00000FFA, 16'h2704}, {wlog[1][63:32], wlog[1][15:0]});
        chk("w2", {32'h00000FF8, 16'h4080}, {wlog[2][63:32], wlog[2][15:0]});
        dst_i = 32'h00003000;
        run(`ISS_OP_UNLINK);
        chk("usp", {1'b1, 32'h00003004}, {sp_we_o, sp_o});
        chk("ureg", {1'b1, 32'h00003000 ^ RDK}, {rf_we_o, rf_data_o});
        src_addr_i = 32'h00005000;
        run(`ISS_OP_DBGWR);
        chk("dbg", {32'h00005000 ^ RDK, 32'h00005004 ^ RDK}, dbg_data_o);
        chk("dbgwe", 1, dbg_we_o);
        chk("nowrites", 3, wlog.size());
        // reset in mid-trap must drop the bus request at once
        op_i = `ISS_OP_TRAP;
        start_i = 1;
        repeat (2) @(posedge sys_clk_i);
        #1;
        start_i = 0;
        sys_rst_i = 1;
        @(posedge sys_clk_i);
        #1;
        sys_rst_i = 0;
        chk("abort", 3'b001, {busy_o, mem_req_o, mem_size_o});
        // unused op code: first start right after release just completes
        run(3'h7);
        chk("nop", 3'b000, {rf_we_o, pc_we_o, mem_req_o});
        test_done;
    end
endmodule // tb_instruction_subset_semantics
